// file: rtl/pra_packet_ram_arbiter_dma.sv
// packet memory data path: dma engine, sram arbiter and host data fifos.
// assumes host and dma controls on core_clk_in; mac side talks by toggles
// with data held stable; sram and mii clock pins are asynchronous.
`timescale 1ns/1ns
module pra_packet_ram_arbiter_dma
   import pra_pkg::*;
#(
   parameter int TX_DEPTH = 4,
   parameter int RX_DEPTH = 4,
   parameter int HW_DEPTH = 4,
   parameter int HR_DEPTH = 4
) (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic mii_transmit_clock_in,
   output logic hnd_clk_en_out,
   output logic hnd_on_internal_out,
   input wire logic host_valid_in,
   input wire pra_host_req_t host_req_in,
   output logic host_rdy_out,
   output logic [WORD_W-1:0] host_rdata_out,
   output logic host_rvalid_out,
   input wire logic dma_tx_start_in,
   input wire logic [RAM_AW-1:0] dma_tx_addr_in,
   input wire logic [DMA_CNT_W-1:0] dma_tx_words_in,
   input wire logic dma_rx_start_in,
   input wire logic [RAM_AW-1:0] dma_rx_addr_in,
   input wire logic [DMA_CNT_W-1:0] dma_rx_words_in,
   output logic dma_tx_busy_out,
   output logic dma_rx_busy_out,
   input wire logic mac_tx_take_tgl_in,
   output logic [HALF_W-1:0] mac_tx_data_out,
   output logic mac_tx_valid_out,
   input wire logic mac_rx_put_tgl_in,
   input wire logic [HALF_W-1:0] mac_rx_data_in,
   output logic mac_rx_space_out,
   output pra_sram_t sram_out,
   input wire logic [WORD_W-1:0] sram_rdata_in
);
   localparam int TXP = $clog2(TX_DEPTH);
   localparam int RXP = $clog2(RX_DEPTH);
   localparam int HWP = $clog2(HW_DEPTH);
   localparam int HRP = $clog2(HR_DEPTH);
   localparam int WENT_W = RAM_AW + BE_W + WORD_W;

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} pra_state_t;
   typedef enum logic [3:0] {
      OWN_HWR = 4'b0001, OWN_HRD = 4'b0010,
      OWN_TX = 4'b0100, OWN_RX = 4'b1000
   } pra_owner_t;

   // -----------------------------------------------------------------
   // clock enables
   // -----------------------------------------------------------------
   // free running from power up: the handler tick must run in reset too
   logic [2:0] div_q = 3'h0;
   logic half_q = 1'b0;
   logic en50, en25;
   assign en50 = (div_q == 3'(ARB_DIV - 1));
   assign en25 = en50 & half_q;
   always_ff @(posedge core_clk_in) begin
      div_q <= en50 ? 3'h0 : div_q + 3'h1;
      if (en50) begin
         half_q <= (HND_TICKS_PER_ARB == 2) ? ~half_q : 1'b1;
      end
   end

   // mii transmit clock presence: edges seen within the loss window
   logic [2:0] mtc_s_q;
   logic [8:0] loss_q;
   logic present;
   assign present = (loss_q < 9'(MTC_LOSS_CYC));
   always_ff @(posedge core_clk_in) begin
      mtc_s_q <= {mtc_s_q[1:0], mii_transmit_clock_in};
      if (srst_in) begin
         loss_q <= 9'(MTC_LOSS_CYC);
      end else if (mtc_s_q[2] != mtc_s_q[1]) begin
         loss_q <= 9'h0;
      end else if (present) begin
         loss_q <= loss_q + 9'h1;
      end
   end

   // internal 25 MHz tick replaces the missing mii clock
   always_ff @(posedge core_clk_in) begin
      hnd_on_internal_out <= srst_in | ~present;
      hnd_clk_en_out <= en25 & (srst_in | ~present);
   end
   // mac side toggles; endec clocks stay inside the mac engine
   logic [2:0] take_s_q, put_s_q;
   logic take_ev, put_ev;
   always_ff @(posedge core_clk_in) begin
      take_s_q <= {take_s_q[1:0], mac_tx_take_tgl_in};
      put_s_q <= {put_s_q[1:0], mac_rx_put_tgl_in};
   end
   assign take_ev = take_s_q[2] ^ take_s_q[1];
   assign put_ev = put_s_q[2] ^ put_s_q[1];

   // sram read data pins pass two stages before capture
   logic [WORD_W-1:0] rd_s1_q, rd_s2_q;
   always_ff @(posedge core_clk_in) begin
      rd_s1_q <= sram_rdata_in;
      rd_s2_q <= rd_s1_q;
   end
   // arbiter state
   pra_state_t st_q;
   pra_owner_t own_q;
   logic [1:0] tick_q;
   logic gen_q, arb_gen_q, last_host_q, last_rx_q;
   logic done;
   assign done = (st_q == ST_RUN) && en50 && (tick_q == 2'(SRAM_TICKS - 1));

   // -----------------------------------------------------------------
   // transmit fifo: words in from memory, halves out to the mac
   // -----------------------------------------------------------------
   logic [WORD_W-1:0] txf_mem [TX_DEPTH];
   logic [TXP-1:0] txf_wp_q, txf_rp_q;
   logic [TXP:0] txf_cnt_q;
   logic txf_hi_q, txf_push, txf_pop;
   assign txf_push = done && (own_q == OWN_TX);
   assign txf_pop = take_ev && txf_hi_q && (txf_cnt_q != '0);
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         txf_wp_q <= '0;
         txf_rp_q <= '0;
         txf_cnt_q <= '0;
         txf_hi_q <= 1'b0;
      end else begin
         if (txf_push) begin
            txf_mem[txf_wp_q] <= rd_s2_q;
            txf_wp_q <= TXP'(txf_wp_q + 1'b1);
         end
         if (txf_pop) begin
            txf_rp_q <= TXP'(txf_rp_q + 1'b1);
         end
         txf_cnt_q <= txf_cnt_q + (TXP+1)'(txf_push) - (TXP+1)'(txf_pop);
         if (take_ev && txf_cnt_q != '0) begin
            txf_hi_q <= ~txf_hi_q;
         end
      end
   end

   // low half goes first, output held in a register for the mac domain
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         mac_tx_data_out <= '0;
         mac_tx_valid_out <= 1'b0;
      end else begin
         mac_tx_valid_out <= (txf_cnt_q != '0) && !txf_pop;
         mac_tx_data_out <= txf_hi_q ? txf_mem[txf_rp_q][WORD_W-1:HALF_W]
                                     : txf_mem[txf_rp_q][HALF_W-1:0];
      end
   end
   // receive fifo: halves in from the mac, words out to memory
   logic [WORD_W-1:0] rxf_mem [RX_DEPTH];
   logic [RXP-1:0] rxf_wp_q, rxf_rp_q;
   logic [RXP:0] rxf_cnt_q;
   logic [HALF_W-1:0] rx_lo_q;
   logic rx_hi_q, rxf_push, rxf_pop, rxf_full;
   assign rxf_full = (rxf_cnt_q == (RXP+1)'(RX_DEPTH));
   // a high half arriving while full is dropped; the mac watches the space flag
   assign rxf_push = put_ev && rx_hi_q && !rxf_full;
   assign rxf_pop = done && (own_q == OWN_RX);
   assign mac_rx_space_out = !rxf_full;
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         rxf_wp_q <= '0;
         rxf_rp_q <= '0;
         rxf_cnt_q <= '0;
         rx_hi_q <= 1'b0;
         rx_lo_q <= '0;
      end else begin
         if (put_ev && !rx_hi_q) begin
            rx_lo_q <= mac_rx_data_in;
         end
         if (put_ev && (!rxf_full || !rx_hi_q)) begin
            rx_hi_q <= ~rx_hi_q;
         end
         if (rxf_push) begin
            rxf_mem[rxf_wp_q] <= {mac_rx_data_in, rx_lo_q};
            rxf_wp_q <= RXP'(rxf_wp_q + 1'b1);
         end
         if (rxf_pop) begin
            rxf_rp_q <= RXP'(rxf_rp_q + 1'b1);
         end
         rxf_cnt_q <= rxf_cnt_q + (RXP+1)'(rxf_push) - (RXP+1)'(rxf_pop);
      end
   end
   // dma counters, one set per direction
   logic [RAM_AW-1:0] tx_addr_q, rx_addr_q;
   logic [DMA_CNT_W-1:0] tx_cnt_q, rx_cnt_q;
   logic tx_want, rx_want;
   assign tx_want = (tx_cnt_q != '0) && (txf_cnt_q != (TXP+1)'(TX_DEPTH));
   assign rx_want = (rx_cnt_q != '0) && (rxf_cnt_q != '0);
   assign dma_tx_busy_out = (tx_cnt_q != '0);
   assign dma_rx_busy_out = (rx_cnt_q != '0);
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         tx_addr_q <= '0;
         tx_cnt_q <= '0;
      end else if (dma_tx_start_in) begin
         tx_addr_q <= dma_tx_addr_in;
         tx_cnt_q <= dma_tx_words_in;
      end else if (txf_push) begin
         tx_addr_q <= tx_addr_q + 1'b1;
         tx_cnt_q <= tx_cnt_q - 1'b1;
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         rx_addr_q <= '0;
         rx_cnt_q <= '0;
      end else if (dma_rx_start_in) begin
         rx_addr_q <= dma_rx_addr_in;
         rx_cnt_q <= dma_rx_words_in;
      end else if (rxf_pop) begin
         rx_addr_q <= rx_addr_q + 1'b1;
         rx_cnt_q <= rx_cnt_q - 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // host fifos and ready
   // -----------------------------------------------------------------
   logic [WENT_W-1:0] hw_mem [HW_DEPTH];
   logic [HWP-1:0] hw_wp_q, hw_rp_q;
   logic [HWP:0] hw_cnt_q;
   logic [WORD_W-1:0] hr_mem [HR_DEPTH];
   logic [HRP-1:0] hr_wp_q, hr_rp_q;
   logic [HRP:0] hr_cnt_q;
   logic [RAM_AW-1:0] exp_q, fetch_q, waddr;
   logic fetch_on_q, stale_q;
   logic [BE_W-1:0] hbe;
   logic hit, restart, acc, hw_push, hw_pop, hr_push, hr_pop, fetch_want;
   assign waddr = host_req_in.addr[BYTE_AW-1:2];
   assign hbe = pra_be_of(host_req_in.addr[1:0], host_req_in.size);
   assign hit = (hr_cnt_q != '0) && !stale_q && (waddr == exp_q);
   // not ready until the fifos can serve the cycle
   assign host_rdy_out = host_valid_in &&
      (host_req_in.write ? (hw_cnt_q != (HWP+1)'(HW_DEPTH)) : hit);
   assign acc = host_valid_in && host_rdy_out;
   assign restart = host_valid_in && !host_req_in.write &&
                    (stale_q || waddr != exp_q || !fetch_on_q);
   assign hw_push = acc && host_req_in.write;
   assign hw_pop = done && (own_q == OWN_HWR);
   assign hr_pop = acc && !host_req_in.write && hbe[BE_W-1];
   // a fetch issued before a restart carries an old generation
   assign hr_push = done && (own_q == OWN_HRD) && (arb_gen_q == gen_q) &&
                    !restart;
   // depth covers one dma cycle plus one host cycle of latency
   assign fetch_want = fetch_on_q && !restart &&
                       (hr_cnt_q != (HRP+1)'(HR_DEPTH));

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         hw_wp_q <= '0;
         hw_rp_q <= '0;
         hw_cnt_q <= '0;
      end else begin
         if (hw_push) begin
            hw_mem[hw_wp_q] <= {waddr, hbe, pra_lane_up(
               host_req_in.addr[1:0], host_req_in.wdata)};
            hw_wp_q <= HWP'(hw_wp_q + 1'b1);
         end
         if (hw_pop) begin
            hw_rp_q <= HWP'(hw_rp_q + 1'b1);
         end
         hw_cnt_q <= hw_cnt_q + (HWP+1)'(hw_push) - (HWP+1)'(hw_pop);
      end
   end

   // read prefetch runs sequentially from the word the host asked for
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         hr_wp_q <= '0;
         hr_rp_q <= '0;
         hr_cnt_q <= '0;
         exp_q <= '0;
         fetch_q <= '0;
         fetch_on_q <= 1'b0;
         stale_q <= 1'b0;
         gen_q <= 1'b0;
      end else if (restart) begin
         hr_wp_q <= '0;
         hr_rp_q <= '0;
         hr_cnt_q <= '0;
         exp_q <= waddr;
         fetch_q <= waddr;
         fetch_on_q <= 1'b1;
         stale_q <= 1'b0;
         gen_q <= ~gen_q;
      end else begin
         if (hw_push) begin
            stale_q <= 1'b1; // a write may overlap prefetched words
         end
         if (hr_push) begin
            hr_mem[hr_wp_q] <= rd_s2_q;
            hr_wp_q <= HRP'(hr_wp_q + 1'b1);
            fetch_q <= fetch_q + 1'b1; // next fetch is the following word
         end
         if (hr_pop) begin
            hr_rp_q <= HRP'(hr_rp_q + 1'b1);
            exp_q <= exp_q + 1'b1;
         end
         hr_cnt_q <= hr_cnt_q + (HRP+1)'(hr_push) - (HRP+1)'(hr_pop);
      end
   end

   // read data handed back one cycle after the access is taken
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         host_rdata_out <= '0;
         host_rvalid_out <= 1'b0;
      end else begin
         host_rvalid_out <= acc && !host_req_in.write;
         if (acc && !host_req_in.write) begin
            host_rdata_out <= pra_lane_dn(host_req_in.addr[1:0],
                                          hr_mem[hr_rp_q]);
         end
      end
   end

   // -----------------------------------------------------------------
   // arbiter: one sram cycle at a time on the 50 MHz tick
   // -----------------------------------------------------------------
   logic host_want, dma_want, pick_host, pick_rx;
   logic [RAM_AW+BE_W+WORD_W-1:0] hw_head;
   assign hw_head = hw_mem[hw_rp_q];
   assign host_want = (hw_cnt_q != '0) || fetch_want;
   assign dma_want = tx_want || rx_want;
   // alternating with the dma gives the host one dword every six ticks
   assign pick_host = host_want && (!dma_want || !last_host_q);
   assign pick_rx = rx_want && (!tx_want || !last_rx_q);

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         st_q <= ST_IDLE;
         own_q <= OWN_HWR;
         tick_q <= '0;
         arb_gen_q <= 1'b0;
         last_host_q <= 1'b0;
         last_rx_q <= 1'b0;
         sram_out <= '{addr: '0, wdata: '0, data_oe: 1'b0, oe_n: 1'b1,
                       we_n: 4'hf, rcv_dma: 1'b0};
      end else if (en50) begin
         case (st_q)
            ST_IDLE: begin
               tick_q <= '0;
               if (pick_host) begin
                  st_q <= ST_RUN;
                  last_host_q <= 1'b1;
                  sram_out.rcv_dma <= 1'b0;
                  if (hw_cnt_q != '0) begin
                     own_q <= OWN_HWR;
                     sram_out.addr <= hw_head[WENT_W-1 -: RAM_AW];
                     sram_out.wdata <= hw_head[WORD_W-1:0];
                     sram_out.we_n <= ~hw_head[WORD_W +: BE_W];
                     sram_out.data_oe <= 1'b1;
                     sram_out.oe_n <= 1'b1;
                  end else begin
                     own_q <= OWN_HRD;
                     arb_gen_q <= gen_q;
                     sram_out.addr <= fetch_q;
                     sram_out.we_n <= 4'hf;
                     sram_out.data_oe <= 1'b0;
                     sram_out.oe_n <= 1'b0;
                  end
               end else if (dma_want) begin
                  st_q <= ST_RUN;
                  last_host_q <= 1'b0;
                  last_rx_q <= pick_rx;
                  own_q <= pick_rx ? OWN_RX : OWN_TX;
                  sram_out.rcv_dma <= pick_rx;
                  sram_out.addr <= pick_rx ? rx_addr_q : tx_addr_q;
                  sram_out.wdata <= rxf_mem[rxf_rp_q];
                  sram_out.we_n <= pick_rx ? 4'h0 : 4'hf;
                  sram_out.data_oe <= pick_rx;
                  sram_out.oe_n <= pick_rx;
               end
            end
            ST_RUN: begin
               tick_q <= tick_q + 2'h1;
               if (tick_q == 2'(SRAM_TICKS - 1)) begin
                  st_q <= ST_IDLE;
                  sram_out.we_n <= 4'hf;
                  sram_out.oe_n <= 1'b1;
                  sram_out.data_oe <= 1'b0;
                  sram_out.rcv_dma <= 1'b0;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

endmodule // pra_packet_ram_arbiter_dma

// file: rtl/pra_pkg.sv
// constants, types and helper functions of the packet ram arbiter and dma.
// assumes one 250 MHz core clock; slower rates are enable pulses from it.
// Behaviour
// - 50 MHz tick runs dma and arbiter
// - 25 MHz tick drives handler when needed
// - endec clocks never reach dma or arbiter
// - mac transmit and receive paths stay independent
// - one 16-bit fifo per direction, mac side
// - dma side of mac fifos holds 32-bit words
// - dma moves words between memory and fifos
// - separate address and count per direction
// - alternate receive and transmit when both wait
// - arbiter serialises host and dma memory cycles
// - memory cycle timed for 25 ns sram
// - host dword every 80 ns, dma included; code gives one every 120 ns
// - write strobes only for written bytes
// - reads fetch full word, bytes steered by address
// - host read and write fifos, any size mix
// - not ready while fifos cannot serve cycle
// - host fifo depth absorbs arbitration delay
package pra_pkg;
   // -----------------------------------------------------------------
   // clock rates and timing
   // -----------------------------------------------------------------
   localparam int CORE_CLK_MHZ = 250;
   localparam int ARB_CLK_MHZ = 50;
   localparam int HND_CLK_MHZ = 25;
   localparam int ARB_DIV = CORE_CLK_MHZ / ARB_CLK_MHZ;
   localparam int HND_TICKS_PER_ARB = ARB_CLK_MHZ / HND_CLK_MHZ;
   localparam int ARB_PERIOD_NS = 1000 / ARB_CLK_MHZ;
   localparam int SRAM_ACCESS_NS = 25;
   localparam int SRAM_TICKS =
      (SRAM_ACCESS_NS + ARB_PERIOD_NS - 1) / ARB_PERIOD_NS;
   localparam int MTC_LOSS_NS = 1000;
   localparam int MTC_LOSS_CYC = MTC_LOSS_NS * CORE_CLK_MHZ / 1000;

   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam int HALF_W = 16;
   localparam int BE_W = 4;
   localparam int RAM_AW = 15;
   localparam int BYTE_AW = 17;
   localparam int DMA_CNT_W = 10;

   typedef enum logic [1:0] {
      PRA_SZ_BYTE = 2'h0,
      PRA_SZ_WORD = 2'h1,
      PRA_SZ_DWORD = 2'h2
   } pra_size_t;

   // host request as issued by the bus interface unit
   typedef struct packed {
      logic write;
      pra_size_t size;
      logic [BYTE_AW-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } pra_host_req_t;

   // sram pins, strobes and output enable active low
   typedef struct packed {
      logic [RAM_AW-1:0] addr;
      logic [WORD_W-1:0] wdata;
      logic data_oe;
      logic oe_n;
      logic [BE_W-1:0] we_n;
      logic rcv_dma;
   } pra_sram_t;

   // byte lanes touched by an access; misaligned spans are cut at lane 3
   function automatic logic [BE_W-1:0] pra_be_of(input logic [1:0] ofs,
                                                  input pra_size_t sz);
      logic [BE_W-1:0] m;
      case (sz)
         PRA_SZ_BYTE: m = 4'h1;
         PRA_SZ_WORD: m = 4'h3;
         default: m = 4'hf;
      endcase
      return BE_W'(m << ofs);
   endfunction

   function automatic logic [WORD_W-1:0] pra_lane_up(input logic [1:0] ofs,
                                                     input logic [WORD_W-1:0] d);
      return WORD_W'(d << {ofs, 3'h0});
   endfunction

   function automatic logic [WORD_W-1:0] pra_lane_dn(input logic [1:0] ofs,
                                                     input logic [WORD_W-1:0] d);
      return WORD_W'(d >> {ofs, 3'h0});
   endfunction
endpackage

// file: tb/pra_arb_checker.sv
// checker: timing relations seen at the ports of the packet memory path.
// assumes it is bound to the top module and shares its core clock.
`timescale 1ns/1ns
module pra_arb_checker
   import pra_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic hnd_clk_en_out,
   input wire logic host_valid_in,
   input wire pra_host_req_t host_req_in,
   input wire logic host_rdy_out,
   input wire logic host_rvalid_out,
   input wire logic dma_tx_start_in,
   input wire logic [DMA_CNT_W-1:0] dma_tx_words_in,
   input wire logic dma_rx_start_in,
   input wire logic [DMA_CNT_W-1:0] dma_rx_words_in,
   input wire logic dma_tx_busy_out,
   input wire logic dma_rx_busy_out,
   input wire pra_sram_t sram_out
);
   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   // one clock domain only, so clock and reset are given once
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);

   chk_hnd_tick_gap: assert property (
      hnd_clk_en_out |=> !hnd_clk_en_out [*8])
      else $error("handler tick repeats too soon");
   chk_rvalid_cause: assert property (
      host_rvalid_out |->
      $past(host_valid_in & host_rdy_out & !host_req_in.write))
      else $error("read data valid without a taken read");
   chk_write_drives_bus: assert property (
      sram_out.we_n != 4'hf |-> sram_out.data_oe && sram_out.oe_n)
      else $error("write strobe without driven data");
   chk_read_no_strobe: assert property (
      !sram_out.oe_n |-> sram_out.we_n == 4'hf && !sram_out.data_oe)
      else $error("read cycle overlaps a write strobe");
   chk_strobe_hold: assert property (
      $changed(sram_out.we_n) && sram_out.we_n != 4'hf
      |=> $stable(sram_out.we_n) [*8])
      else $error("write strobes shorter than a memory cycle");
   chk_read_addr_hold: assert property (
      $fell(sram_out.oe_n)
      |=> (!sram_out.oe_n && $stable(sram_out.addr)) [*8])
      else $error("read address not held for a memory cycle");
   chk_reset_idle: assert property (
      $fell(srst_in) |-> sram_out.oe_n && sram_out.we_n == 4'hf
      && !sram_out.data_oe && !dma_tx_busy_out && !dma_rx_busy_out)
      else $error("memory bus not idle after reset");
   chk_tx_busy_load: assert property (
      dma_tx_start_in && dma_tx_words_in != '0 |=> dma_tx_busy_out)
      else $error("transmit count not loaded");
   chk_rx_busy_load: assert property (
      dma_rx_start_in && dma_rx_words_in != '0 |=> dma_rx_busy_out)
      else $error("receive count not loaded");
endmodule // pra_arb_checker

// file: tb/pra_sram_model.sv
// partner: external 32-bit packet sram with byte write strobes.
// assumes low active strobes and output enable held through each cycle.
`timescale 1ns/1ns
module pra_sram_model
   import pra_pkg::*;
#(
   parameter int LAT_CYC = 2
) (
   input wire logic clk_in,
   input wire pra_sram_t pins_in,
   output logic [WORD_W-1:0] rdata_out
);
   logic [WORD_W-1:0] mem [0:(1<<RAM_AW)-1];
   logic [WORD_W-1:0] last_q = '0;
   int wait_q = 0;
   // -----------------------------------------------------------------
   // array update
   // -----------------------------------------------------------------
   // only lanes whose strobe is low change; others keep their bytes
   always @(posedge clk_in) begin
      for (int i = 0; i < BE_W; i++) begin
         if (!pins_in.we_n[i]) begin
            mem[pins_in.addr][8*i +: 8] <= pins_in.wdata[8*i +: 8];
         end
      end
      wait_q <= pins_in.oe_n ? 0 : wait_q + 1;
      if (!pins_in.oe_n) begin
         last_q <= mem[pins_in.addr];
      end
   end
   // word after the access delay; a released bus shows the last inverted
   assign rdata_out = (!pins_in.oe_n && wait_q >= LAT_CYC) ?
      mem[pins_in.addr] : ~last_q;
endmodule // pra_sram_model

// file: tb/pra_packet_ram_arbiter_dma_bench.sv
// bench: host reads and writes, dma in both directions, handler tick.
// assumes default fifo depths and the sram model as memory partner.
`timescale 1ns/1ns
module pra_packet_ram_arbiter_dma_bench;
   import pra_pkg::*;
   logic core_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic mii_clk = 1'b0, mii_run = 1'b0, host_valid = 1'b0, tx_go = 1'b0;
   logic rx_go = 1'b0, take_tgl = 1'b0, put_tgl = 1'b0;
   pra_host_req_t host_req = '0;
   logic [HALF_W-1:0] rx_half = '0;
   logic hnd_en, hnd_int, rdy, rvalid, tx_busy, rx_busy, tx_valid, rx_space;
   logic [WORD_W-1:0] rdata, ram_q, q;
   logic [HALF_W-1:0] tx_half;
   pra_sram_t ram_pins;
   int err_total = 0, total_checks = 0, w;

   pra_packet_ram_arbiter_dma u_dut (.core_clk_in(core_clk_in),
      .srst_in(srst_in), .mii_transmit_clock_in(mii_clk),
      .hnd_clk_en_out(hnd_en), .hnd_on_internal_out(hnd_int),
      .host_valid_in(host_valid), .host_req_in(host_req),
      .host_rdy_out(rdy), .host_rdata_out(rdata), .host_rvalid_out(rvalid),
      .dma_tx_start_in(tx_go), .dma_tx_addr_in(15'h0010),
      .dma_tx_words_in(10'h002), .dma_rx_start_in(rx_go),
      .dma_rx_addr_in(15'h0020), .dma_rx_words_in(10'h002),
      .dma_tx_busy_out(tx_busy), .dma_rx_busy_out(rx_busy),
      .mac_tx_take_tgl_in(take_tgl), .mac_tx_data_out(tx_half),
      .mac_tx_valid_out(tx_valid), .mac_rx_put_tgl_in(put_tgl),
      .mac_rx_data_in(rx_half), .mac_rx_space_out(rx_space),
      .sram_out(ram_pins), .sram_rdata_in(ram_q));
   pra_sram_model #(.LAT_CYC(3)) u_ram (.clk_in(core_clk_in),
      .pins_in(ram_pins), .rdata_out(ram_q));

   // -----------------------------------------------------------------
   // clocks and shared tasks
   // -----------------------------------------------------------------
   initial begin
      forever #2 core_clk_in = ~core_clk_in;
   end
   // phy clock only runs while a scenario asks for it
   always #20 if (mii_run) mii_clk = ~mii_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // request held until the edge where ready is high; wdata sits in lane 0
   task automatic host_op(input logic wr, input pra_size_t sz,
                          input logic [16:0] a, input logic [31:0] d);
      w = 0;
      @(posedge core_clk_in);
      host_valid <= 1'b1;
      host_req <= '{write: wr, size: sz, addr: a, wdata: d};
      @(negedge core_clk_in);
      while (rdy !== 1'b1 && w < 400) begin
         @(negedge core_clk_in);
         w++;
      end
      @(posedge core_clk_in);
      host_valid <= 1'b0;
      @(negedge core_clk_in);
      chk(rvalid, !wr);
      q = rdata;
   endtask

   // take one transmit half and put one receive half at the same edge
   task automatic mac_step(input logic [15:0] exp, input logic [15:0] put);
      repeat (30) @(negedge core_clk_in);
      chk(tx_valid, 1'b1);
      chk(tx_half, exp);
      @(posedge core_clk_in);
      take_tgl <= ~take_tgl;
      put_tgl <= ~put_tgl;
      rx_half <= put;
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   // no phy clock: internal tick every 10 cycles; phy clock stops it
   task automatic t_handler_clock();
      repeat (300) @(negedge core_clk_in);
      chk(hnd_int, 1'b1);
      w = 0;
      repeat (40) begin
         @(negedge core_clk_in);
         w += hnd_en;
      end
      chk(w, 4);
      mii_run = 1'b1;
      repeat (80) @(negedge core_clk_in);
      chk(hnd_int, 1'b0);
      chk(hnd_en, 1'b0);
   endtask

   // byte lanes on read, strobes on partial writes
   task automatic t_host_data();
      host_op(1'b0, PRA_SZ_BYTE, 17'h00022, '0);
      chk(w > 0, 1'b1);
      chk(q[7:0], 8'h33);
      host_op(1'b0, PRA_SZ_DWORD, 17'h00020, '0);
      chk(q, 32'h44332211);
      host_op(1'b1, PRA_SZ_WORD, 17'h00026, 32'h0000beef);
      host_op(1'b1, PRA_SZ_BYTE, 17'h00025, 32'h0000005a);
      host_op(1'b1, PRA_SZ_DWORD, 17'h00028, 32'h13579bdf);
      repeat (150) @(negedge core_clk_in);
      chk(u_ram.mem[9], 32'hbeef5aaa);
      chk(u_ram.mem[10], 32'h13579bdf);
   endtask

   // both dma directions at once with a host read in between
   task automatic t_dma_duplex();
      chk(rx_space, 1'b1);
      @(posedge core_clk_in);
      tx_go <= 1'b1;
      rx_go <= 1'b1;
      @(posedge core_clk_in);
      tx_go <= 1'b0;
      rx_go <= 1'b0;
      host_op(1'b0, PRA_SZ_DWORD, 17'h00020, '0);
      chk(q, 32'h44332211);
      chk(w < 40, 1'b1);
      mac_step(16'h4321, 16'hc0de);
      mac_step(16'h8765, 16'hfeed);
      mac_step(16'hcba9, 16'h1234);
      mac_step(16'h0fed, 16'h5678);
      w = 0;
      while ((tx_busy | rx_busy) !== 1'b0 && w < 300) begin
         @(negedge core_clk_in);
         w++;
      end
      chk({tx_busy, rx_busy}, 2'h0);
      chk(u_ram.mem[32], 32'hfeedc0de);
      chk(u_ram.mem[33], 32'h56781234);
   endtask

   initial begin
      u_ram.mem[8] = 32'h44332211;
      u_ram.mem[9] = 32'haaaaaaaa;
      u_ram.mem[16] = 32'h87654321;
      u_ram.mem[17] = 32'h0fedcba9;
      repeat (3) @(posedge core_clk_in);
      srst_in <= 1'b0;
      t_handler_clock();
      t_host_data();
      t_dma_duplex();
      results();
   end

   // scenarios need about 800 cycles; this is far beyond
   initial begin
      #100000;
      err_total++;
      results();
   end
endmodule // pra_packet_ram_arbiter_dma_bench

bind pra_packet_ram_arbiter_dma pra_arb_checker u_chk (
   .core_clk_in(core_clk_in), .srst_in(srst_in),
   .hnd_clk_en_out(hnd_clk_en_out), .host_valid_in(host_valid_in),
   .host_req_in(host_req_in), .host_rdy_out(host_rdy_out),
   .host_rvalid_out(host_rvalid_out), .dma_tx_start_in(dma_tx_start_in),
   .dma_tx_words_in(dma_tx_words_in), .dma_rx_start_in(dma_rx_start_in),
   .dma_rx_words_in(dma_rx_words_in), .dma_tx_busy_out(dma_tx_busy_out),
   .dma_rx_busy_out(dma_rx_busy_out), .sram_out(sram_out));
